// ---- blhmi_pkg.sv ----
// constants and types of the operator interface controller
package blhmi_pkg;
   // ********************
   // timing
   // ********************
   localparam int unsigned CLK_HZ = 25_000_000; // system clock rate
   localparam int unsigned STARTUP_BLINK_MS = 1000; // all-lamp blink after reset
   localparam int unsigned TEST_TIMEOUT_S = 180; // test mode auto exit
   localparam int unsigned SETUP_TIMEOUT_S = 5; // setup calibration limit
   localparam int unsigned LEARN_TIMEOUT_S = 180; // learn detection limit
   localparam int unsigned DWELL_MS = 1000; // function lamp dwell while held
   localparam int unsigned BLINK_HALF_MS = 250; // blink half period
   localparam int unsigned TICK_MS = 1; // base tick period
   localparam int unsigned DEBOUNCE_MS = 20; // button debounce time
   localparam int unsigned BEEP_SHORT_MS = 100; // high beep length and gap
   localparam int unsigned BEEP_LONG_MS = 1000; // low beep length
   localparam int unsigned HIGH_BEEPS = 3; // beeps on successful save
   // clock cycles per base tick
   localparam int unsigned TICK_CYC = (CLK_HZ / 1000) * TICK_MS;
   // ********************
   // lamp bit positions
   // ********************
   localparam int unsigned LAMP_RESULT = 0; // red result lamp
   localparam int unsigned LAMP_SERIAL = 1; // serial activity lamp
   localparam int unsigned LAMP_PHASE = 2; // reading-phase lamp
   localparam int unsigned LAMP_SUCCESS = 3; // green success lamp
   localparam int unsigned LAMP_READY = 4; // green ready lamp
   localparam int unsigned LAMP_N = 5;
   // function lamps share status lamps: test, focus, setup, learn
   localparam int unsigned LAMP_F_TEST = LAMP_READY;
   localparam int unsigned LAMP_F_FOCUS = LAMP_SUCCESS;
   localparam int unsigned LAMP_F_SETUP = LAMP_PHASE;
   localparam int unsigned LAMP_F_LEARN = LAMP_SERIAL;
   localparam logic [4:0] LAMPS_OFF = 5'h00;
   localparam logic [4:0] LAMPS_ALL = 5'h1f;
   // ********************
   // states
   // ********************
   typedef enum logic [3:0] {
      BLHMI_START = 4'h0, // startup blink
      BLHMI_NORMAL = 4'h1, // status indication
      BLHMI_HOLD = 4'h2, // button held, stepping functions
      BLHMI_TEST = 4'h3, // bar graph
      BLHMI_FOCUS = 4'h4, // aiming pointers on
      BLHMI_SETUP = 4'h5, // calibration running
      BLHMI_LEARN = 4'h6, // detection running
      BLHMI_DONE = 4'h7 // result shown while beeper finishes
   } blhmi_state_t;
   typedef enum logic [1:0] {
      BLHMI_FN_TEST = 2'h0,
      BLHMI_FN_FOCUS = 2'h1,
      BLHMI_FN_SETUP = 2'h2,
      BLHMI_FN_LEARN = 2'h3
   } blhmi_fn_t;
endpackage : blhmi_pkg

// ---- blhmi_top.sv ----
// operator interface controller: push button, status lamps, beeper, aiming pointers
//
// Behaviour
// - blink all five lamps one second after reset
// - red result lamp on no-read phase end
// - serial lamp follows main serial activity
// - serial lamp steady when on fieldbus
// - phase lamp follows active reading phase
// - success lamp confirms good read
// - ready lamp shows reader ready
// - network lamp on link, supply lamp powered
// - result lamp acknowledges button press
// - hold steps function lamps, release enters
// - test mode bar graph of good-read rate
// - test no-read: only result lamp blinking
// - test exits on press or three minutes
// - focus mode: pointers on, focus lamp blinks
// - press leaves focus, pointers off
// - setup blinks; success steady plus three beeps
// - setup five second timeout: off, long beep
// - learn blinks; success steady plus three beeps
// - learn three minute timeout: off, long beep
// - each learn replaces previous learned code
// - error blinks result and ready only
`timescale 1ns/1ps
module blhmi_top
   import blhmi_pkg::*;
#(
   parameter int unsigned DWELL_TICKS = DWELL_MS / TICK_MS, // function lamp dwell in ticks
   parameter int unsigned TEST_TICKS = TEST_TIMEOUT_S * 1000 / TICK_MS, // test timeout in ticks
   parameter int unsigned SETUP_TICKS = SETUP_TIMEOUT_S * 1000 / TICK_MS, // setup timeout in ticks
   parameter int unsigned LEARN_TICKS = LEARN_TIMEOUT_S * 1000 / TICK_MS, // learn timeout in ticks
   parameter int unsigned TICK_CYCLES = TICK_CYC // clock cycles per tick
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // operator button pin, high when pressed
   input wire logic button,
   // reader status, same clock
   input wire logic phase_active, // a reading phase is running
   input wire logic phase_end, // pulse: reading phase ended
   input wire logic code_read, // with phase_end: a code was decoded
   input wire logic serial_active, // main serial port busy
   input wire logic fieldbus_attached, // connected through the fieldbus box
   input wire logic reader_ready, // reader ready to operate
   input wire logic error_present, // error condition
   input wire logic eth_link, // ethernet link up
   input wire logic power_good, // supply present
   input wire logic [2:0] good_rate_level, // test mode good-read rate, 0..5
   input wire logic cal_done, // pulse: calibration saved
   input wire logic learn_done, // pulse: learned code saved
   // function requests to the reader
   output logic cal_run, // calibration procedure running
   output logic learn_run, // learn procedure running, replaces old code
   output logic test_run, // test statistics running
   // lamps and annunciators
   output logic [4:0] status_lamp, // result, serial, phase, success, ready
   output logic ethernet_link_lamp,
   output logic supply_present_lamp,
   output logic aim_pointer,
   output logic beep_high,
   output logic beep_low
);
   // ****************************************
   // elaboration checks
   // ****************************************
   initial begin
      if (TICK_CYCLES < 1 || DWELL_TICKS < 1 || TEST_TICKS < 1 || SETUP_TICKS < 1 || LEARN_TICKS < 1) begin
         $error("timing parameters below one");
      end
   end

   localparam int unsigned TW = $clog2(TICK_CYCLES + 1); // tick divider width
   localparam int unsigned CW = 24; // mode timer width, up to ~16M ticks
   localparam logic [CW-1:0] START_T = CW'(STARTUP_BLINK_MS / TICK_MS);
   localparam logic [CW-1:0] DEB_T = CW'(DEBOUNCE_MS / TICK_MS);
   localparam logic [CW-1:0] BLINK_T = CW'(BLINK_HALF_MS / TICK_MS);
   localparam logic [CW-1:0] SHORT_T = CW'(BEEP_SHORT_MS / TICK_MS);
   localparam logic [CW-1:0] LONG_T = CW'(BEEP_LONG_MS / TICK_MS);
   localparam logic [2:0] BEEP_N = 3'(HIGH_BEEPS * 2 - 1); // on/off phases

   // ****************************************
   // input synchroniser and tick divider
   // ****************************************
   logic btn_s1, btn_s2; // first stage read only by second
   logic [TW-1:0] tick_cnt, next_tick_cnt;
   logic tick, next_tick; // one-cycle pulse each tick

   // divider next values
   always_comb begin
      next_tick = 1'b0;
      next_tick_cnt = tick_cnt + TW'(1);
      if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
         next_tick_cnt = '0;
         next_tick = 1'b1;
      end
   end

   // register sync chain and divider
   always_ff @(posedge clk) begin
      if (reset) begin
         btn_s1 <= 1'b0;
         btn_s2 <= 1'b0;
         tick_cnt <= '0;
         tick <= 1'b0;
      end else begin
         btn_s1 <= button;
         btn_s2 <= btn_s1;
         tick_cnt <= next_tick_cnt;
         tick <= next_tick;
      end
   end

   // ****************************************
   // debounce and blink base
   // ****************************************
   logic btn, next_btn; // debounced level
   logic [CW-1:0] deb_cnt, next_deb_cnt;
   logic [CW-1:0] blink_cnt, next_blink_cnt;
   logic blink, next_blink; // shared blink phase keeps lamps in step
   logic press, release_ev; // edges of debounced level

   // a new level is taken only after it stood stable
   always_comb begin
      next_btn = btn;
      next_deb_cnt = deb_cnt;
      next_blink = blink;
      next_blink_cnt = blink_cnt;
      if (btn_s2 == btn) begin
         next_deb_cnt = '0;
      end else if (tick) begin
         next_deb_cnt = deb_cnt + CW'(1);
         if (deb_cnt + CW'(1) >= DEB_T) begin
            next_btn = btn_s2;
            next_deb_cnt = '0;
         end
      end
      if (tick) begin
         next_blink_cnt = blink_cnt + CW'(1);
         if (blink_cnt + CW'(1) >= BLINK_T) begin
            next_blink_cnt = '0;
            next_blink = ~blink;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         btn <= 1'b0;
         deb_cnt <= '0;
         blink <= 1'b1;
         blink_cnt <= '0;
      end else begin
         btn <= next_btn;
         deb_cnt <= next_deb_cnt;
         blink <= next_blink;
         blink_cnt <= next_blink_cnt;
      end
   end

   assign press = next_btn & ~btn;
   assign release_ev = ~next_btn & btn;

   // ****************************************
   // main mode sequencer
   // ****************************************
   blhmi_state_t state, next_state;
   blhmi_fn_t fn, next_fn; // function lamp currently offered
   logic [CW-1:0] timer, next_timer; // ticks spent in state or dwell
   logic noread, next_noread; // last phase ended without a code
   logic saved, next_saved; // setup/learn outcome shown in done state
   blhmi_fn_t done_fn, next_done_fn;
   logic beep_go_hi, beep_go_lo; // one-cycle beeper requests

   // function lamp for a selection, used by hold and done states
   function automatic logic [4:0] fn_lamp(input blhmi_fn_t f);
      logic [4:0] v;
      v = LAMPS_OFF;
      unique case (f)
         BLHMI_FN_TEST: v[LAMP_F_TEST] = 1'b1;
         BLHMI_FN_FOCUS: v[LAMP_F_FOCUS] = 1'b1;
         BLHMI_FN_SETUP: v[LAMP_F_SETUP] = 1'b1;
         BLHMI_FN_LEARN: v[LAMP_F_LEARN] = 1'b1;
      endcase
      return v;
   endfunction : fn_lamp

   // state transitions and timers
   always_comb begin
      next_state = state;
      next_fn = fn;
      next_timer = tick ? timer + CW'(1) : timer;
      next_noread = noread;
      next_saved = saved;
      next_done_fn = done_fn;
      beep_go_hi = 1'b0;
      beep_go_lo = 1'b0;
      if (phase_end) begin
         next_noread = ~code_read;
      end
      unique case (state)
         BLHMI_START: begin
            if (timer >= START_T) begin
               next_state = BLHMI_NORMAL;
               next_timer = '0;
            end
         end
         BLHMI_NORMAL: begin
            if (press) begin
               next_state = BLHMI_HOLD;
               next_fn = BLHMI_FN_TEST;
               next_timer = '0;
            end
         end
         BLHMI_HOLD: begin
            if (release_ev) begin
               next_timer = '0;
               unique case (fn)
                  BLHMI_FN_TEST: next_state = BLHMI_TEST;
                  BLHMI_FN_FOCUS: next_state = BLHMI_FOCUS;
                  BLHMI_FN_SETUP: next_state = BLHMI_SETUP;
                  BLHMI_FN_LEARN: next_state = BLHMI_LEARN;
               endcase
            end else if (timer >= CW'(DWELL_TICKS)) begin
               next_fn = blhmi_fn_t'(fn + 2'h1);
               next_timer = '0;
            end
         end
         BLHMI_TEST: begin
            if (press || timer >= CW'(TEST_TICKS)) begin
               next_state = BLHMI_NORMAL;
               next_timer = '0;
            end
         end
         BLHMI_FOCUS: begin
            if (press) begin
               next_state = BLHMI_NORMAL;
               next_timer = '0;
            end
         end
         BLHMI_SETUP, BLHMI_LEARN: begin
            next_done_fn = (state == BLHMI_SETUP) ? BLHMI_FN_SETUP : BLHMI_FN_LEARN;
            if ((state == BLHMI_SETUP) ? cal_done : learn_done) begin
               next_state = BLHMI_DONE;
               next_saved = 1'b1;
               beep_go_hi = 1'b1;
               next_timer = '0;
            end else if (timer >= ((state == BLHMI_SETUP) ? CW'(SETUP_TICKS) : CW'(LEARN_TICKS))) begin
               next_state = BLHMI_DONE;
               next_saved = 1'b0;
               beep_go_lo = 1'b1;
               next_timer = '0;
            end
         end
         BLHMI_DONE: begin
            // outcome shown for the long beep time, then back to status
            if (timer >= LONG_T) begin
               next_state = BLHMI_NORMAL;
               next_timer = '0;
            end
         end
         default: begin
            next_state = BLHMI_NORMAL;
            next_timer = '0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= BLHMI_START;
         fn <= BLHMI_FN_TEST;
         timer <= '0;
         noread <= 1'b0;
         saved <= 1'b0;
         done_fn <= BLHMI_FN_SETUP;
      end else begin
         state <= next_state;
         fn <= next_fn;
         timer <= next_timer;
         noread <= next_noread;
         saved <= next_saved;
         done_fn <= next_done_fn;
      end
   end

   // ****************************************
   // beeper sequencer
   // ****************************************
   logic [2:0] bphase, next_bphase; // remaining high beep phases
   logic [CW-1:0] btimer, next_btimer;
   logic next_beep_high, next_beep_low;

   // high beeps alternate on/off; the low beep is one long tone
   always_comb begin
      next_bphase = bphase;
      next_btimer = tick ? btimer + CW'(1) : btimer;
      next_beep_high = beep_high;
      next_beep_low = beep_low;
      if (beep_go_hi) begin
         next_bphase = BEEP_N;
         next_beep_high = 1'b1;
         next_btimer = '0;
      end else if (beep_go_lo) begin
         next_beep_low = 1'b1;
         next_btimer = '0;
      end else if (beep_low && btimer >= LONG_T) begin
         next_beep_low = 1'b0;
      end else if (bphase != 3'h0 && btimer >= SHORT_T) begin
         next_bphase = bphase - 3'h1;
         next_beep_high = (bphase != 3'h1) && ~beep_high;
         next_btimer = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         bphase <= 3'h0;
         btimer <= '0;
         beep_high <= 1'b0;
         beep_low <= 1'b0;
      end else begin
         bphase <= next_bphase;
         btimer <= next_btimer;
         beep_high <= next_beep_high;
         beep_low <= next_beep_low;
      end
   end

   // ****************************************
   // lamp and output drive
   // ****************************************
   logic [4:0] next_lamp;
   logic next_aim, next_cal, next_learn, next_test;

   // bar graph: level n lights the n lowest lamps
   function automatic logic [4:0] bar(input logic [2:0] lvl);
      logic [4:0] v;
      v = LAMPS_OFF;
      for (int i = 0; i < LAMP_N; i++) begin
         v[i] = (3'(i) < lvl);
      end
      return v;
   endfunction : bar

   always_comb begin
      next_lamp = LAMPS_OFF;
      next_aim = 1'b0;
      next_cal = 1'b0;
      next_learn = 1'b0;
      next_test = 1'b0;
      unique case (state)
         BLHMI_START: next_lamp = blink ? LAMPS_ALL : LAMPS_OFF;
         BLHMI_NORMAL: begin
            if (error_present) begin
               next_lamp[LAMP_RESULT] = blink;
               next_lamp[LAMP_READY] = blink;
            end else begin
               next_lamp[LAMP_RESULT] = noread;
               next_lamp[LAMP_SERIAL] = serial_active | fieldbus_attached;
               next_lamp[LAMP_PHASE] = phase_active;
               next_lamp[LAMP_SUCCESS] = ~noread;
               next_lamp[LAMP_READY] = reader_ready;
            end
         end
         BLHMI_HOLD: begin
            next_lamp = fn_lamp(fn);
            next_lamp[LAMP_RESULT] = 1'b1;
         end
         BLHMI_TEST: begin
            next_test = 1'b1;
            if (good_rate_level == 3'h0) begin
               next_lamp[LAMP_RESULT] = blink;
            end else begin
               next_lamp = bar(good_rate_level);
            end
         end
         BLHMI_FOCUS: begin
            next_aim = 1'b1;
            next_lamp[LAMP_F_FOCUS] = blink;
         end
         BLHMI_SETUP: begin
            next_cal = 1'b1;
            next_lamp[LAMP_F_SETUP] = blink;
         end
         BLHMI_LEARN: begin
            next_learn = 1'b1;
            next_lamp[LAMP_F_LEARN] = blink;
         end
         BLHMI_DONE: next_lamp = saved ? fn_lamp(done_fn) : LAMPS_OFF;
         default: next_lamp = LAMPS_OFF;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         status_lamp <= LAMPS_OFF;
         ethernet_link_lamp <= 1'b0;
         supply_present_lamp <= 1'b0;
         aim_pointer <= 1'b0;
         cal_run <= 1'b0;
         learn_run <= 1'b0;
         test_run <= 1'b0;
      end else begin
         status_lamp <= next_lamp;
         ethernet_link_lamp <= eth_link;
         supply_present_lamp <= power_good;
         aim_pointer <= next_aim;
         cal_run <= next_cal;
         learn_run <= next_learn;
         test_run <= next_test;
      end
   end
endmodule : blhmi_top

// ---- blhmi_top_asserts.sv ----
// port checks of the operator interface controller
`timescale 1ns/1ps
module blhmi_top_asserts
   import blhmi_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC // clock cycles per tick
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // watched inputs
   input wire logic eth_link,
   input wire logic power_good,
   input wire logic [2:0] good_rate_level,
   // watched outputs
   input wire logic cal_run,
   input wire logic learn_run,
   input wire logic test_run,
   input wire logic [4:0] status_lamp,
   input wire logic ethernet_link_lamp,
   input wire logic supply_present_lamp,
   input wire logic aim_pointer,
   input wire logic beep_high,
   input wire logic beep_low
);
   // ********************
   // helper counters
   // ********************
   int unsigned lo_len; // cycles the low beep has stood
   int unsigned hi_len; // cycles the high beep has stood
   // counters restart whenever the beep is quiet
   always_ff @(posedge clk) begin
      lo_len <= (reset || !beep_low) ? 0 : lo_len + 1;
      hi_len <= (reset || !beep_high) ? 0 : hi_len + 1;
   end
   // ********************
   // properties
   // ********************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // a cycle straight after reset still shows the reset value
   property p_eth; !$past(reset) |-> ethernet_link_lamp == $past(eth_link); endproperty
   property p_pwr; !$past(reset) |-> supply_present_lamp == $past(power_good); endproperty
   property p_one_mode; $onehot0({cal_run, learn_run, test_run, aim_pointer}); endproperty
   property p_focus; aim_pointer && $past(aim_pointer) |-> (status_lamp & 5'h17) == 5'h00; endproperty
   property p_bar;
      test_run && $past(test_run, 2) && $stable(good_rate_level) && good_rate_level inside {[1:5]}
      |-> status_lamp == 5'((6'h01 << good_rate_level) - 6'h01);
   endproperty
   property p_noread;
      test_run && $past(test_run, 2) && $stable(good_rate_level) && good_rate_level == 3'h0
      |-> status_lamp[4:1] == 4'h0;
   endproperty
   property p_end_beep; $fell(cal_run) || $fell(learn_run) |-> ##[0:4] (beep_high || beep_low); endproperty
   property p_beep_excl; !(beep_high && beep_low); endproperty
   // length judged at the fall, with slack for tick phase
   property p_low_len; $fell(beep_low) |-> lo_len >= 990 * TICK_CYCLES && lo_len <= 1010 * TICK_CYCLES; endproperty
   property p_high_len; $fell(beep_high) |-> hi_len >= 95 * TICK_CYCLES && hi_len <= 105 * TICK_CYCLES; endproperty
   a_eth: assert property (p_eth) else $error("network lamp wrong");
   a_pwr: assert property (p_pwr) else $error("supply lamp wrong");
   a_one_mode: assert property (p_one_mode) else $error("two functions active");
   a_focus: assert property (p_focus) else $error("focus lamps wrong");
   a_bar: assert property (p_bar) else $error("bar graph wrong");
   a_noread: assert property (p_noread) else $error("no-read lamps wrong");
   a_end_beep: assert property (p_end_beep) else $error("no end beep");
   a_beep_excl: assert property (p_beep_excl) else $error("both beeps at once");
   a_low_len: assert property (p_low_len) else $error("low beep length");
   a_high_len: assert property (p_high_len) else $error("high beep length");
   c_bar: cover property (test_run && good_rate_level == 3'h5);
   c_focus: cover property (aim_pointer);
   c_low: cover property ($fell(beep_low));
   c_high: cover property ($fell(beep_high));
endmodule : blhmi_top_asserts
bind blhmi_top blhmi_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// ---- blhmi_operator.sv ----
// operator model: presses, holds and releases the push button
`timescale 1ns/1ps
module blhmi_operator
   import blhmi_pkg::*;
(
   // clock
   input wire logic clk,
   // requests from the bench
   input wire logic tap, // one short press
   input wire logic go, // hold until the lamp of fn is seen laps times
   input wire blhmi_fn_t fn,
   input wire logic [1:0] laps,
   // what the operator sees and does
   input wire logic [4:0] status_lamp,
   output logic button,
   output logic busy
);
   int n, seen; // wait count, lamp sightings
   logic hold, lit, was_lit; // hold mode, lamp now, lamp before
   logic [4:0] want; // lamp pattern that means release now
   initial begin
      button = 1'b0;
      busy = 1'b0;
   end
   // contacts chatter on each press; the debounce must hide it
   always begin
      @(posedge clk);
      if (tap || go) begin
         hold = go;
         want = 5'h01 | (5'h01 << (4 - int'(fn)));
         #2 busy = 1'b1;
         repeat (3) begin
            button = 1'b1;
            @(posedge clk);
            #2 button = 1'b0;
            @(posedge clk);
            #2;
         end
         button = 1'b1;
         seen = 0;
         was_lit = 1'b0;
         // release a hold while the wanted lamp is lit, a tap after 80 cycles
         for (n = 0; n < 800 && (hold ? seen < int'(laps) : n < 80); n++) begin
            @(posedge clk);
            #1 lit = status_lamp == want;
            seen += lit && !was_lit;
            was_lit = lit;
         end
         @(posedge clk);
         #2 button = 1'b0;
         repeat (60) @(posedge clk);
         #2 busy = 1'b0;
      end
   end
endmodule : blhmi_operator

// ---- tb_top.sv ----
// self-checking bench for the operator interface controller
`timescale 1ns/1ps
module tb_top;
   import blhmi_pkg::*;
   localparam int unsigned TC = 2; // cycles per tick, kept small for run time
   logic clk = 1'b0, reset = 1'b1, tap = 1'b0, go = 1'b0, button, busy;
   logic phase_active = 1'b0, phase_end = 1'b0, code_read = 1'b0, serial_active = 1'b0;
   logic fieldbus_attached = 1'b0, reader_ready = 1'b1, error_present = 1'b0, eth_link = 1'b0;
   logic power_good = 1'b1, cal_done = 1'b0, learn_done = 1'b0;
   logic [2:0] good_rate_level = 3'h3;
   logic cal_run, learn_run, test_run, ethernet_link_lamp, supply_present_lamp, aim_pointer, beep_high, beep_low;
   logic [4:0] status_lamp;
   blhmi_fn_t fn = BLHMI_FN_TEST;
   logic [1:0] laps = 2'h1;
   int mismatches = 0, tests_run = 0;
   // ********************
   // clock, design and operator
   // ********************
   always #20 clk = ~clk;
   // dwell outlasts the debounce, so a release lands on the lit lamp
   blhmi_top #(.DWELL_TICKS(60), .TEST_TICKS(600), .SETUP_TICKS(100), .LEARN_TICKS(100), .TICK_CYCLES(TC)) dut (.*);
   blhmi_operator op (.*);
   // ********************
   // shared tasks
   // ********************
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test
   task automatic check(input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // inputs always move 2 ns after the rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : cyc
   task automatic wait_sig(ref logic s, input logic v, input int lim);
      for (int n = 0; n < lim && s !== v; n++) cyc(1);
      check(s, v);
      if (s !== v) stop_test();
   endtask : wait_sig
   // hand a request to the operator, wait till done
   task automatic act(input logic t, input blhmi_fn_t f, input logic [1:0] l);
      fn = f;
      laps = l;
      tap = t;
      go = !t;
      cyc(1);
      tap = 1'b0;
      go = 1'b0;
      cyc(1);
      for (int n = 0; n < 1500 && busy; n++) cyc(1);
      check(busy, 1'b0);
      if (busy) stop_test();
   endtask : act
   // ********************
   // scenarios
   // ********************
   task automatic t_startup;
      int bad = 0, on = 0;
      for (int n = 0; n < 1900; n++) begin
         cyc(1);
         bad += status_lamp != 5'h00 && status_lamp != 5'h1f;
         on += status_lamp == 5'h1f;
      end
      check(bad, 0);
      check(on > 400 && on < 1500, 1);
      cyc(200);
      check(status_lamp, 5'h18);
   endtask : t_startup
   task automatic t_normal;
      int bad = 0, on = 0;
      eth_link = 1'b1;
      reader_ready = 1'b0;
      phase_active = 1'b1;
      cyc(2);
      check(status_lamp, 5'h0c);
      phase_active = 1'b0;
      phase_end = 1'b1;
      cyc(1);
      phase_end = 1'b0;
      cyc(1);
      check(status_lamp, 5'h01);
      phase_end = 1'b1;
      code_read = 1'b1;
      cyc(1);
      phase_end = 1'b0;
      serial_active = 1'b1;
      cyc(2);
      check(status_lamp, 5'h0a);
      serial_active = 1'b0;
      fieldbus_attached = 1'b1;
      cyc(2);
      check(status_lamp[1], 1);
      fieldbus_attached = 1'b0;
      error_present = 1'b1;
      for (int n = 0; n < 1100; n++) begin
         cyc(1);
         bad += status_lamp[3:1] != 3'h0 || status_lamp[0] != status_lamp[4];
         on += status_lamp[0];
      end
      check(bad, 0);
      check(on > 300 && on < 800, 1);
      error_present = 1'b0;
      cyc(2);
   endtask : t_normal
   task automatic t_wrap;
      logic [31:0] seq = 0;
      logic [3:0] last = 4'h0;
      int ran = 0;
      fork
         act(1'b0, BLHMI_FN_TEST, 2'h2);
         for (int n = 0; n < 800; n++) begin
            cyc(1);
            ran += test_run;
            if (status_lamp[0] && $onehot(status_lamp[4:1]) && status_lamp[4:1] != last) begin
               last = status_lamp[4:1];
               seq = {seq[27:0], last};
            end
         end
      join
      check(seq, 32'h84218);
      check(ran > 0, 1);
      wait_sig(test_run, 1'b0, 1500);
   endtask : t_wrap
   task automatic t_test;
      int on = 0, n;
      good_rate_level = 3'h5;
      act(1'b0, BLHMI_FN_TEST, 2'h1);
      wait_sig(test_run, 1'b1, 50);
      check(status_lamp, 5'h1f);
      good_rate_level = 3'h0;
      for (n = 0; n < 600; n++) begin
         cyc(1);
         on += status_lamp[0];
      end
      check(on > 0 && on < 600, 1);
      act(1'b1, BLHMI_FN_TEST, 2'h1);
      check(test_run, 0);
      act(1'b0, BLHMI_FN_TEST, 2'h1);
      for (n = 0; n < 1400 && test_run; n++) cyc(1);
      check(n > 1000 && n < 1300, 1);
   endtask : t_test
   task automatic t_focus;
      int on = 0;
      act(1'b0, BLHMI_FN_FOCUS, 2'h1);
      wait_sig(aim_pointer, 1'b1, 50);
      for (int n = 0; n < 1100; n++) begin
         cyc(1);
         on += status_lamp[LAMP_F_FOCUS];
      end
      check(on > 300 && on < 800, 1);
      act(1'b1, BLHMI_FN_FOCUS, 2'h1);
      check(aim_pointer, 0);
   endtask : t_focus
   task automatic t_proc(input blhmi_fn_t f, input int b, input logic ok);
      int hi = 0, lo = 0, on = 0;
      logic hb = 1'b0, lb = 1'b0;
      act(1'b0, f, 2'h1);
      check({cal_run, learn_run}, f == BLHMI_FN_SETUP ? 2'h2 : 2'h1);
      cal_done = ok && f == BLHMI_FN_SETUP;
      learn_done = ok && f == BLHMI_FN_LEARN;
      cyc(1);
      cal_done = 1'b0;
      learn_done = 1'b0;
      for (int n = 0; n < 3000; n++) begin
         cyc(1);
         hi += beep_high && !hb;
         lo += beep_low && !lb;
         hb = beep_high;
         lb = beep_low;
         on += status_lamp[b];
      end
      check({hi[7:0], lo[7:0]}, ok ? 16'h0300 : 16'h0001);
      check(on > 1500, ok);
   endtask : t_proc
   // ********************
   // main sequence
   // ********************
   initial begin
      cyc(4);
      reset = 1'b0;
      t_startup();
      t_normal();
      t_wrap();
      t_test();
      t_focus();
      t_proc(BLHMI_FN_SETUP, LAMP_F_SETUP, 1'b1);
      t_proc(BLHMI_FN_SETUP, LAMP_F_SETUP, 1'b0);
      t_proc(BLHMI_FN_LEARN, LAMP_F_LEARN, 1'b1);
      t_proc(BLHMI_FN_LEARN, LAMP_F_LEARN, 1'b0);
      t_proc(BLHMI_FN_LEARN, LAMP_F_LEARN, 1'b1);
      stop_test();
   end
endmodule : tb_top
